// File: rtl/mdu_unit.sv
// Multiply/divide unit: sequencer handshake, operand fetch, timing and result.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - signed 16-bit multiply/divide, double-length results
// - two-word instruction, 15-bit absolute operand address
// - operand address never indexed; index holds data
// - multiply takes 12.25 to 17.5 microseconds
// - multiplier from accumulator, multiplicand from memory
// - 31-bit product split index/accumulator, bit 0 copy
// - multiply never sets overflow
// - non-overflowing divide takes 24.5 microseconds
// - dividend from index and accumulator bits 1-15
// - accumulator bit 0 ignored by divide
// - quotient to accumulator, remainder to index
// - remainder takes dividend sign or zero
// - detect quotient not fitting 16 bits
// - overflow sets flag, dividend kept, bit 0 copied
// - overflowing divide ends after 8.75 microseconds
module mdu_unit #(
  parameter int WORD_W = 16,
  parameter int ADDR_W = 15
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic startReq,
  input wire mdu_pkg::mdu_req_type reqIn,
  output logic memRdReq,
  output logic [ADDR_W-1:0] memAddr,
  input wire logic memRdValid,
  input wire logic [WORD_W-1:0] memRdData,
  output logic busy,
  output logic resValid,
  output mdu_pkg::mdu_res_type resOut
);
  ////////////////////////////////////////////////////////////////////////////
  // Vector index 15 is documented bit 0 (sign); index 0 is documented bit 15.
  typedef enum logic [2:0] {
    MDU_IDLE = 3'h0,
    MDU_FETCH = 3'h1,
    MDU_RUN = 3'h3,
    MDU_WAIT = 3'h2,
    MDU_DONE = 3'h6
  } mdu_state_type;

  mdu_state_type state_q, state_d;
  mdu_pkg::mdu_op_type op_q, op_d;
  logic [WORD_W-1:0] acc_q, acc_d;
  logic [WORD_W-1:0] idx_q, idx_d;
  logic [WORD_W-1:0] opnd_q, opnd_d;
  logic [mdu_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [4:0] step_q, step_d;
  logic [mdu_pkg::CNT_W-1:0] target_q, target_d;
  logic memRdReq_q, memRdReq_d;
  logic [ADDR_W-1:0] memAddr_q, memAddr_d;
  logic busy_q, busy_d;
  logic resValid_q, resValid_d;
  mdu_pkg::mdu_res_type res_q, res_d;

  logic coreLoad, coreStep, coreDiv, multBit;
  logic [WORD_W-1:0] coreA;
  logic [2*WORD_W-2:0] coreB;
  logic [2*WORD_W-1:0] prod;
  logic [WORD_W-1:0] quotMag, remMag;

  // Signed views of the operands.
  logic [2*WORD_W-2:0] dividend, dividendMag;
  logic [WORD_W-1:0] divisorMag, mulAMag, mulBMag;
  logic dvdNeg, dvsNeg, mulNeg, ovfHit;
  logic [2*WORD_W-2:0] prodSigned;
  logic [WORD_W-1:0] quotSigned, remSigned;
  logic [WORD_W:0] quotLimit;
  logic [2*WORD_W:0] dvdWide, ovfBound;

  ////////////////////////////////////////////////////////////////////////////
  mdu_shift_core #(
    .WORD_W(WORD_W)
  ) u_core (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(coreLoad),
    .isDiv(coreDiv),
    .step(coreStep),
    .opA(coreA),
    .opB(coreB),
    .prodOut(prod),
    .quotOut(quotMag),
    .remOut(remMag),
    .multBitOut(multBit)
  );

  always_comb begin
    dividend = {idx_q, acc_q[WORD_W-2:0]};
    dvdNeg = dividend[2*WORD_W-2];
    dividendMag = dvdNeg ? (~dividend + 1'b1) : dividend;
    dvsNeg = opnd_q[WORD_W-1];
    divisorMag = dvsNeg ? (~opnd_q + 1'b1) : opnd_q;
    mulAMag = acc_q[WORD_W-1] ? (~acc_q + 1'b1) : acc_q;
    mulBMag = opnd_q[WORD_W-1] ? (~opnd_q + 1'b1) : opnd_q;
    mulNeg = acc_q[WORD_W-1] ^ opnd_q[WORD_W-1];
    // quotient range check
    // The truncated quotient fits while the dividend magnitude stays below the
    // divisor magnitude times 2^15, or times 2^15+1 for a negative quotient,
    // because -2^15 is still representable. A zero divisor always overflows.
    quotLimit = (dvdNeg ^ dvsNeg) ? {2'b01, {(WORD_W-2){1'b0}}, 1'b1}
                                  : {2'b01, {(WORD_W-1){1'b0}}};
    dvdWide = {2'b00, dividendMag};
    ovfBound = {{(WORD_W+1){1'b0}}, divisorMag} * {{WORD_W{1'b0}}, quotLimit};
    ovfHit = (divisorMag == '0) || (dvdWide >= ovfBound);
    remSigned = dvdNeg ? (~remMag + 1'b1) : remMag;
    quotSigned = (dvdNeg ^ dvsNeg) ? (~quotMag + 1'b1) : quotMag;
    prodSigned = mulNeg ? (~prod[2*WORD_W-2:0] + 1'b1) : prod[2*WORD_W-2:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    acc_d = acc_q;
    idx_d = idx_q;
    opnd_d = opnd_q;
    cnt_d = cnt_q;
    step_d = step_q;
    target_d = target_q;
    memRdReq_d = 1'b0;
    memAddr_d = memAddr_q;
    busy_d = busy_q;
    resValid_d = 1'b0;
    res_d = res_q;
    coreLoad = 1'b0;
    coreStep = 1'b0;
    coreDiv = (op_q == mdu_pkg::MDU_OP_DIV);
    coreA = (op_q == mdu_pkg::MDU_OP_DIV) ? divisorMag : mulAMag;
    coreB = (op_q == mdu_pkg::MDU_OP_DIV) ? dividendMag : {{(WORD_W-1){1'b0}}, mulBMag};
    if (state_q != MDU_IDLE) begin
      cnt_d = mdu_pkg::CNT_W'(cnt_q + 1'b1);
    end
    case (state_q)
      MDU_IDLE: begin
        if (startReq) begin
          op_d = reqIn.op;
          acc_d = reqIn.acc;
          idx_d = reqIn.idx;
          memAddr_d = reqIn.addr;
          memRdReq_d = 1'b1;
          busy_d = 1'b1;
          cnt_d = '0;
          state_d = MDU_FETCH;
        end
      end
      MDU_FETCH: begin
        if (memRdValid) begin
          opnd_d = memRdData;
          state_d = MDU_RUN;
          step_d = '0;
        end else begin
          memRdReq_d = 1'b1;
        end
      end
      MDU_RUN: begin
        if (step_q == '0) begin
          coreLoad = 1'b1;
          step_d = 5'h1;
          if (op_q == mdu_pkg::MDU_OP_DIV) begin
            target_d = ovfHit ? mdu_pkg::CNT_W'(mdu_pkg::DIV_OVF_CYC - 1)
                              : mdu_pkg::CNT_W'(mdu_pkg::DIV_CYC - 1);
            if (ovfHit) begin
              res_d.idx = idx_q;
              res_d.acc = {idx_q[WORD_W-1], acc_q[WORD_W-2:0]};
              res_d.ovf = 1'b1;
              state_d = MDU_WAIT;
            end
          end else begin
            target_d = mdu_pkg::CNT_W'(mdu_pkg::MUL_MIN_CYC - 1);
          end
        end else if (step_q <= 5'(WORD_W)) begin
          coreStep = 1'b1;
          step_d = 5'(step_q + 1'b1);
          if (op_q == mdu_pkg::MDU_OP_MUL && multBit) begin
            target_d = mdu_pkg::CNT_W'(target_q + ((mdu_pkg::MUL_MAX_CYC - mdu_pkg::MUL_MIN_CYC) / WORD_W));
          end
        end else begin
          if (op_q == mdu_pkg::MDU_OP_DIV) begin
            res_d.acc = quotSigned;
            res_d.idx = remSigned;
          end else begin
            // product split with bit 0 copy
            res_d.idx = prodSigned[2*WORD_W-2:WORD_W-1];
            res_d.acc = {prodSigned[2*WORD_W-2], prodSigned[WORD_W-2:0]};
          end
          res_d.ovf = 1'b0;
          state_d = MDU_WAIT;
        end
      end
      MDU_WAIT: begin
        if (cnt_q >= target_q) begin
          resValid_d = 1'b1;
          state_d = MDU_DONE;
        end
      end
      MDU_DONE: begin
        busy_d = 1'b0;
        state_d = MDU_IDLE;
      end
      default: begin
        busy_d = 1'b0;
        state_d = MDU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= MDU_IDLE;
      op_q <= mdu_pkg::MDU_OP_MUL;
      acc_q <= '0;
      idx_q <= '0;
      opnd_q <= '0;
      cnt_q <= '0;
      step_q <= '0;
      target_q <= '0;
      memRdReq_q <= 1'b0;
      memAddr_q <= '0;
      busy_q <= 1'b0;
      resValid_q <= 1'b0;
      res_q <= '0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      acc_q <= acc_d;
      idx_q <= idx_d;
      opnd_q <= opnd_d;
      cnt_q <= cnt_d;
      step_q <= step_d;
      target_q <= target_d;
      memRdReq_q <= memRdReq_d;
      memAddr_q <= memAddr_d;
      busy_q <= busy_d;
      resValid_q <= resValid_d;
      res_q <= res_d;
    end
  end

  assign memRdReq = memRdReq_q;
  assign memAddr = memAddr_q;
  assign busy = busy_q;
  assign resValid = resValid_q;
  assign resOut = res_q;
endmodule : mdu_unit
`default_nettype wire

// File: rtl/mdu_pkg.sv
// Shared constants and types for the multiply/divide unit.
package mdu_pkg;
  // Word and field widths.
  localparam int WORD_W = 16;
  localparam int ADDR_W = 15;
  // Clock rate and documented execution times.
  localparam int CLK_PERIOD_PS = 25000;
  localparam int MUL_MIN_TIME_NS = 12250;
  localparam int MUL_MAX_TIME_NS = 17500;
  localparam int DIV_TIME_NS = 24500;
  localparam int DIV_OVF_TIME_NS = 8750;
  // Cycle counts; least times round up, longest times round down.
  localparam int MUL_MIN_CYC = (MUL_MIN_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MUL_MAX_CYC = (MUL_MAX_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int DIV_CYC = (DIV_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int DIV_OVF_CYC = (DIV_OVF_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int CNT_W = 10;
  // Operation select in the first instruction word.
  typedef enum logic [0:0] {
    MDU_OP_MUL = 1'h0,
    MDU_OP_DIV = 1'h1
  } mdu_op_type;
  // Start request from the sequencer.
  typedef struct packed {
    mdu_op_type op;
    logic [WORD_W-1:0] acc;
    logic [WORD_W-1:0] idx;
    logic [ADDR_W-1:0] addr;
  } mdu_req_type;
  // Result written back to the register file.
  typedef struct packed {
    logic [WORD_W-1:0] acc;
    logic [WORD_W-1:0] idx;
    logic ovf;
  } mdu_res_type;
endpackage : mdu_pkg

// File: rtl/mdu_shift_core.sv
// Bit-serial shift-add multiplier and restoring divider datapath.
`timescale 1ns/1ps
`default_nettype none
module mdu_shift_core #(
  parameter int WORD_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic isDiv,
  input wire logic step,
  input wire logic [WORD_W-1:0] opA,
  input wire logic [2*WORD_W-2:0] opB,
  output logic [2*WORD_W-1:0] prodOut,
  output logic [WORD_W-1:0] quotOut,
  output logic [WORD_W-1:0] remOut,
  output logic multBitOut
);
  // Magnitudes are processed; signs are fixed up by the caller.
  logic [2*WORD_W-1:0] acc_q, acc_d;
  logic [WORD_W-1:0] mq_q, mq_d;
  logic [WORD_W:0] trial;

  always_comb begin
    acc_d = acc_q;
    mq_d = mq_q;
    trial = '0;
    if (load) begin
      if (isDiv) begin
        acc_d = {1'b0, opB};
      end else begin
        acc_d = '0;
      end
      mq_d = opA;
    end else if (step) begin
      if (isDiv) begin
        trial = {1'b0, acc_q[2*WORD_W-2:WORD_W-1]} - {1'b0, mq_q};
        if (!trial[WORD_W]) begin
          acc_d = {trial[WORD_W-1:0], acc_q[WORD_W-2:0], 1'b1};
        end else begin
          acc_d = {acc_q[2*WORD_W-2:0], 1'b0};
        end
      end else begin
        // Partial sums enter at the top of acc as it shifts right; multiplier bits leave mq at bit 0.
        acc_d = {1'b0, acc_q[2*WORD_W-1:1]};
        if (mq_q[0]) begin
          acc_d[2*WORD_W-1:WORD_W-1] = {1'b0, acc_q[2*WORD_W-1:WORD_W]} + {1'b0, opB[WORD_W-1:0]};
        end
        mq_d = {1'b0, mq_q[WORD_W-1:1]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= '0;
      mq_q <= '0;
    end else begin
      acc_q <= acc_d;
      mq_q <= mq_d;
    end
  end

  assign prodOut = acc_q;
  assign quotOut = acc_q[WORD_W-1:0];
  assign remOut = acc_q[2*WORD_W-1:WORD_W];
  assign multBitOut = mq_q[0];
endmodule : mdu_shift_core
`default_nettype wire

// File: sim/mdu_unit_assertions.sv
// Port checker for the multiply/divide unit, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module mdu_unit_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic startReq,
  input wire mdu_pkg::mdu_req_type reqIn,
  input wire logic memRdReq,
  input wire logic [14:0] memAddr,
  input wire logic memRdValid,
  input wire logic [15:0] memRdData,
  input wire logic busy,
  input wire logic resValid,
  input wire mdu_pkg::mdu_res_type resOut
);
  logic [11:0] cnt_q;
  mdu_pkg::mdu_req_type req_q;
  logic take;
  logic isDiv;
  assign take = startReq && !busy;
  assign isDiv = req_q.op == mdu_pkg::MDU_OP_DIV;
  // The counter starts at the taking edge, so memory latency is part of the time.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 12'h000;
      req_q <= '0;
    end else if (take) begin
      cnt_q <= 12'h001;
      req_q <= reqIn;
    end else if (busy) begin
      cnt_q <= cnt_q + 12'h001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  property p_start; take |=> busy && memRdReq; endproperty
  a_start: assert property (p_start)
    else $error("no busy or read request after start");
  property p_addr; take |=> memAddr == $past(reqIn.addr); endproperty
  a_addr: assert property (p_addr)
    else $error("operand address altered");
  property p_rd_drop; memRdReq && memRdValid |=> !memRdReq; endproperty
  a_rd_drop: assert property (p_rd_drop)
    else $error("read request kept after data");
  property p_end; resValid |=> !busy && !resValid; endproperty
  a_end: assert property (p_end)
    else $error("busy or result pulse too long");
  property p_hold; busy && !resValid |=> busy; endproperty
  a_hold: assert property (p_hold)
    else $error("busy dropped before result");
  property p_mul_time; resValid && !isDiv |-> cnt_q >= 12'h1e7 && cnt_q <= 12'h2bf; endproperty
  a_mul_time: assert property (p_mul_time)
    else $error("multiply time out of range");
  property p_div_time; resValid && isDiv && !resOut.ovf |-> cnt_q inside {[12'h3d1:12'h3d7]};
  endproperty
  a_div_time: assert property (p_div_time)
    else $error("divide time wrong");
  property p_ovf_time; resValid && resOut.ovf |-> cnt_q inside {[12'h15b:12'h161]}; endproperty
  a_ovf_time: assert property (p_ovf_time)
    else $error("overflow divide time wrong");
  property p_mul_novf; resValid && !isDiv |-> !resOut.ovf; endproperty
  a_mul_novf: assert property (p_mul_novf)
    else $error("multiply set overflow");
  property p_bit0; resValid && (!isDiv || resOut.ovf) |-> resOut.acc[15] == resOut.idx[15];
  endproperty
  a_bit0: assert property (p_bit0)
    else $error("accumulator sign bit not copied");
  property p_keep; resValid && resOut.ovf |-> resOut.idx == req_q.idx
    && resOut.acc[14:0] == req_q.acc[14:0]; endproperty
  a_keep: assert property (p_keep)
    else $error("dividend not kept on overflow");
  property p_rem; resValid && isDiv && !resOut.ovf |-> resOut.idx == 16'h0000
    || resOut.idx[15] == req_q.idx[15]; endproperty
  a_rem: assert property (p_rem)
    else $error("remainder sign differs from dividend");
endmodule : mdu_unit_checker
bind mdu_unit mdu_unit_checker CHK (.clk(clk), .sys_rst(sys_rst), .startReq(startReq),
  .reqIn(reqIn), .memRdReq(memRdReq), .memAddr(memAddr), .memRdValid(memRdValid),
  .memRdData(memRdData), .busy(busy), .resValid(resValid), .resOut(resOut));
`default_nettype wire

// File: sim/mdu_mem_model.sv
// Memory model that answers the unit's operand reads after a set latency.
`timescale 1ns/1ps
`default_nettype none
module mdu_mem_model (
  input wire logic clk,
  input wire logic [7:0] lat,
  input wire logic memRdReq,
  input wire logic [14:0] memAddr,
  output logic memRdValid,
  output logic [15:0] memRdData
);
  logic [15:0] mem [0:32767];
  logic [7:0] waitCnt_q = 8'h00;
  logic done_q = 1'b0;
  initial begin
    memRdValid = 1'b0;
    memRdData = 16'h0000;
  end
  // one read answered
  // Data toggles outside the valid cycle so stale values look right only on alternate cycles.
  always @(posedge clk) begin
    memRdValid <= 1'b0;
    memRdData <= ~memRdData;
    if (!memRdReq) begin
      waitCnt_q <= 8'h00;
      done_q <= 1'b0;
    end else if (!done_q && waitCnt_q == lat) begin
      memRdValid <= 1'b1;
      memRdData <= mem[memAddr];
      done_q <= 1'b1;
    end else if (!done_q) begin
      waitCnt_q <= waitCnt_q + 8'h01;
    end
  end
endmodule : mdu_mem_model
`default_nettype wire

// File: sim/testbench.sv
// Self-checking testbench for the multiply/divide unit.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic startReq = 1'b0;
  mdu_pkg::mdu_req_type reqIn = '0;
  logic memRdReq, memRdValid, busy, resValid;
  logic [14:0] memAddr;
  logic [15:0] memRdData;
  logic [7:0] lat = 8'h00;
  mdu_pkg::mdu_res_type resOut;
  int error_cnt = 0;
  int tests_run = 0;
  always #12.5 clk = ~clk;
  mdu_unit DUT (.clk(clk), .sys_rst(sys_rst), .startReq(startReq), .reqIn(reqIn),
    .memRdReq(memRdReq), .memAddr(memAddr), .memRdValid(memRdValid),
    .memRdData(memRdData), .busy(busy), .resValid(resValid), .resOut(resOut));
  mdu_mem_model MEM (.clk(clk), .lat(lat), .memRdReq(memRdReq), .memAddr(memAddr),
    .memRdValid(memRdValid), .memRdData(memRdData));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // A poke is a start request while busy, which must leave the result alone.
  task automatic op(input logic d, input logic [15:0] a, input logic [15:0] x,
    input logic [15:0] m, input logic [14:0] ad, input bit poke);
    longint p, dv, q, r;
    logic [15:0] ea, ex;
    logic eo;
    MEM.mem[ad] = m;
    do begin @(posedge clk); #1; end while (busy !== 1'b0);
    startReq = 1'b1;
    reqIn = {d, a, x, ad};
    @(posedge clk); #1;
    startReq = 1'b0;
    if (poke) begin
      repeat (4) @(posedge clk);
      #1 startReq = 1'b1;
      reqIn = {~d, ~a, ~x, ~ad};
      @(posedge clk); #1;
      startReq = 1'b0;
    end
    for (int n = 0; n < 1100 && resValid !== 1'b1; n++) begin @(posedge clk); #1; end
    chk("done", 16'h0001, {15'h0000, resValid});
    if (!d) begin
      p = longint'($signed(a)) * longint'($signed(m));
      ex = p[30:15];
      ea = {p[30], p[14:0]};
      eo = 1'b0;
    end else begin
      dv = longint'($signed({x, a[14:0]}));
      eo = m == 16'h0000;
      if (!eo) begin
        q = dv / longint'($signed(m));
        r = dv % longint'($signed(m));
        eo = q > 64'sh7fff || q < -64'sh8000;
      end
      ex = eo ? x : r[15:0];
      ea = eo ? {x[15], a[14:0]} : q[15:0];
    end
    chk("index", ex, resOut.idx);
    chk("accumulator", ea, resOut.acc);
    chk("overflow", {15'h0000, eo}, {15'h0000, resOut.ovf});
  endtask : op
  ////////////////////////////////////////////////////////////////////////////////
  task automatic sc_reset;
    chk("busy", 16'h0000, {15'h0000, busy});
    chk("read", 16'h0000, {15'h0000, memRdReq});
  endtask : sc_reset
  task automatic sc_mul;
    lat = 8'h00;
    op(1'b0, 16'h0003, 16'h1234, 16'h0005, 15'h7fff, 1'b0);
    op(1'b0, 16'hfffe, 16'h0000, 16'h0007, 15'h0000, 1'b0);
    lat = 8'h14;
    op(1'b0, 16'h8000, 16'h0000, 16'h0001, 15'h0101, 1'b0);
    op(1'b0, 16'h7fff, 16'hffff, 16'h7fff, 15'h2aaa, 1'b0);
    op(1'b0, 16'h8000, 16'h0000, 16'h7fff, 15'h5555, 1'b0);
  endtask : sc_mul
  task automatic sc_div;
    lat = 8'h03;
    op(1'b1, 16'h0064, 16'h0000, 16'h0007, 15'h0010, 1'b0);
    op(1'b1, 16'h8064, 16'h0000, 16'h0007, 15'h0010, 1'b0);
    op(1'b1, 16'h1234, 16'hffff, 16'h0009, 15'h0020, 1'b0);
    op(1'b1, 16'h4321, 16'h0002, 16'hfff3, 15'h7ffe, 1'b0);
    op(1'b1, 16'h0000, 16'hc000, 16'h4000, 15'h0030, 1'b0);
  endtask : sc_div
  task automatic sc_ovf;
    lat = 8'h00;
    op(1'b1, 16'h0000, 16'h4000, 16'h4000, 15'h0040, 1'b0);
    op(1'b1, 16'h7abc, 16'h8123, 16'h0000, 15'h0050, 1'b0);
    op(1'b1, 16'h0001, 16'h0100, 16'h0002, 15'h0060, 1'b0);
  endtask : sc_ovf
  task automatic sc_refused;
    lat = 8'h08;
    op(1'b0, 16'h0123, 16'h0000, 16'hff00, 15'h0070, 1'b1);
    op(1'b1, 16'h0123, 16'h0002, 16'h0100, 15'h0071, 1'b1);
  endtask : sc_refused
  task automatic give_verdict;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #1000000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    sc_reset();
    sc_mul();
    sc_div();
    sc_ovf();
    sc_refused();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
